// [dv/vectored_interrupt_priority_unit_bench.sv]
`timescale 1ns/10ps
module vectored_interrupt_priority_unit_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] req = 32'h0;
    logic [31:0] is_pin = 32'h0000_0020;
    logic [15:0] rdata;
    logic irq, enter, resume, ret;
    logic [6:0] vnum;
    logic [23:0] vaddr, rpc;
    logic [3:0] lvl;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    vipu_top uut (.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .SRC_REQ(req), .SRC_IS_PIN(is_pin), .CORE_IRQ(irq), .CORE_VECNUM(vnum),
        .CORE_VEC_ADDR(vaddr), .CORE_LEVEL(lvl), .CORE_ENTER(enter), .CORE_RESUME(resume),
        .CORE_RESET_PC(rpc), .CORE_RETURN(ret));
    vipu_core_model core (.clk(clk), .rstn(rstn), .enter(enter), .ret(ret));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            results();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task pulse(input logic [31:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= 32'h0;
    endtask
    task quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            chk(irq, 1'b0);
        end
    endtask
    task serve(input int s, input logic [3:0] lv, input logic [23:0] ad);
        int i;
        logic [3:0] l0;
        l0 = lvl;
        for (i = 0; i < 30 && irq !== 1'b1; i++) @(negedge clk);
        chk(irq, 1'b1);
        for (i = 0; i < 8 && enter !== 1'b1; i++) @(negedge clk);
        chk(i, 3);
        chk(vnum, s);
        chk(vaddr, ad);
        chk(lvl, lv);
        wr(vipu_pkg::OFF_FLAG0 + 8'(s / 16), ~(16'h1 << (s % 16)));
        for (i = 0; i < 30 && resume !== 1'b1; i++) @(negedge clk);
        chk(resume, 1'b1);
        @(negedge clk);
        chk(lvl, l0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        rd(vipu_pkg::OFF_STATUS, 16'h0000);
        wr(vipu_pkg::OFF_CORE_CTRL, 16'h0008);
        rd(vipu_pkg::OFF_CORE_CTRL, 16'h0000);
        rd(vipu_pkg::OFF_PRIO_BASE, 16'h4444);
        rd(8'hff, 16'h0000);
        chk(rpc, 24'h000000);
        $display("test regs done");
    endtask
    task t_pin;
        @(posedge clk);
        req <= 32'h0000_0020;
        repeat (6) @(posedge clk);
        rd(vipu_pkg::OFF_FLAG0, 16'h0020);
        wr(vipu_pkg::OFF_FLAG0, 16'hffdf);
        rd(vipu_pkg::OFF_FLAG0, 16'h0000);
        @(posedge clk);
        req <= 32'h0;
        $display("test pin done");
    endtask
    task t_tie;
        wr(vipu_pkg::OFF_ENA0, 16'h0208);
        pulse(32'h0000_0208);
        serve(3, 4'h4, 24'h00001a);
        serve(9, 4'h4, 24'h000026);
        $display("test tie done");
    endtask
    task t_mask;
        wr(vipu_pkg::OFF_STATUS, 16'h00a0);
        pulse(32'h0000_0200);
        quiet(20);
        rd(vipu_pkg::OFF_STATUS, 16'h00a0);
        wr(vipu_pkg::OFF_ICTL1, 16'h8000);
        wr(vipu_pkg::OFF_STATUS, 16'h0000);
        rd(vipu_pkg::OFF_STATUS, 16'h00a0);
        wr(vipu_pkg::OFF_ICTL1, 16'h0000);
        wr(vipu_pkg::OFF_PRIO_BASE + 8'h02, 16'h4464);
        serve(9, 4'h6, 24'h000026);
        wr(vipu_pkg::OFF_STATUS, 16'h0000);
        $display("test mask done");
    endtask
    task t_alt;
        wr(vipu_pkg::OFF_ICTL2, 16'h8000);
        wr(vipu_pkg::OFF_PRIO_BASE + 8'h07, 16'h7444);
        pulse(32'h8000_0000);
        quiet(10);
        rd(vipu_pkg::OFF_FLAG1, 16'h8000);
        wr(vipu_pkg::OFF_ENA1, 16'h8000);
        serve(31, 4'h7, 24'h00014e);
        rd(vipu_pkg::OFF_FLAG1, 16'h0000);
        $display("test alt done");
    endtask
    task results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_pin();
        t_tie();
        t_mask();
        t_alt();
        results();
    end
endmodule

// [dv/vipu_checker_sva.sv]
`timescale 1ns/10ps
module vipu_checker (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // register port
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    // core side
    input wire logic CORE_IRQ,
    input wire logic [6:0] CORE_VECNUM,
    input wire logic [23:0] CORE_VEC_ADDR,
    input wire logic [3:0] CORE_LEVEL,
    input wire logic CORE_ENTER,
    input wire logic CORE_RESUME,
    input wire logic [23:0] CORE_RESET_PC,
    input wire logic CORE_RETURN
);
    logic in_svc_q;
    logic [3:0] lvl_save_q;
    logic [23:0] pri_a;
    logic [23:0] alt_a;
    assign pri_a = vipu_pkg::PRI_TABLE_BASE + ({17'h0, CORE_VECNUM} + 24'h8) * vipu_pkg::ENTRY_STRIDE;
    assign alt_a = pri_a + 24'hfc;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            in_svc_q <= 1'b0;
        end else if (CORE_ENTER) begin
            in_svc_q <= 1'b1;
        end else if (CORE_RESUME) begin
            in_svc_q <= 1'b0;
        end
    end
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            lvl_save_q <= 4'h0;
        end else if (CORE_IRQ) begin
            lvl_save_q <= CORE_LEVEL;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_irq_enter; CORE_IRQ |-> ##3 CORE_ENTER; endproperty
    a_irq_enter: assert property (p_irq_enter) else $error("entry not three cycles after request");
    property p_irq_pulse; CORE_IRQ |=> !CORE_IRQ; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("request line held too long");
    property p_level_raise; CORE_IRQ |=> CORE_LEVEL > $past(CORE_LEVEL); endproperty
    a_level_raise: assert property (p_level_raise) else $error("level not raised on accept");
    property p_restore; CORE_RESUME |=> CORE_LEVEL == lvl_save_q; endproperty
    a_restore: assert property (p_restore) else $error("level not restored on resume");
    property p_resume; CORE_RETURN && in_svc_q |-> ##3 CORE_RESUME; endproperty
    a_resume: assert property (p_resume) else $error("return latency wrong");
    property p_no_nest; in_svc_q && !CORE_RESUME |-> !CORE_IRQ; endproperty
    a_no_nest: assert property (p_no_nest) else $error("request during service");
    property p_vec; CORE_ENTER |-> CORE_VEC_ADDR == pri_a || CORE_VEC_ADDR == alt_a; endproperty
    a_vec: assert property (p_vec) else $error("vector address off table");
    property p_reset_pc; CORE_RESET_PC == 24'h000000; endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("reset address not zero");
    property p_rdata_idle; !$past(REG_RD) |-> REG_RDATA == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_msb; CORE_LEVEL[3] == 1'b0; endproperty
    a_msb: assert property (p_msb) else $error("priority msb set by software");
    c_irq: cover property (CORE_IRQ);
    c_enter: cover property (CORE_ENTER);
    c_resume: cover property (CORE_RESUME);
endmodule
bind vipu_top vipu_checker u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CORE_IRQ(CORE_IRQ), .CORE_VECNUM(CORE_VECNUM), .CORE_VEC_ADDR(CORE_VEC_ADDR), .CORE_LEVEL(CORE_LEVEL),
    .CORE_ENTER(CORE_ENTER), .CORE_RESUME(CORE_RESUME), .CORE_RESET_PC(CORE_RESET_PC), .CORE_RETURN(CORE_RETURN));

// [dv/vipu_core_model.sv]
`timescale 1ns/10ps
module vipu_core_model #(
    parameter int SVC = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // core handshake
    input wire logic enter,
    output logic ret
);
    int cnt;
    // ----------------------------------------
    // routine runs a fixed time, then exits
    // every vector slot, primary or alternate, leads to this one routine
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            ret <= 1'b0;
        end else begin
            ret <= (cnt == 1);
            if (enter) begin
                cnt <= SVC;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// [logic/vipu_pkg.sv]
package vipu_pkg;
    // ------------------------------------------------------------
    // vector table geometry
    // ------------------------------------------------------------
    localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
    localparam int unsigned TABLE_ENTRIES = 126;
    localparam int unsigned TRAP_COUNT = 8;
    localparam int unsigned USER_VECTORS = 118;
    localparam int unsigned IMPL_SOURCES = 32;
    localparam logic [23:0] ENTRY_STRIDE = 24'h000002;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CORE_CTRL = 8'h01;
    localparam logic [7:0] OFF_ICTL1 = 8'h02;
    localparam logic [7:0] OFF_ICTL2 = 8'h03;
    localparam logic [7:0] OFF_FLAG0 = 8'h04;
    localparam logic [7:0] OFF_FLAG1 = 8'h05;
    localparam logic [7:0] OFF_ENA0 = 8'h06;
    localparam logic [7:0] OFF_ENA1 = 8'h07;
    localparam logic [7:0] OFF_PRIO_BASE = 8'h08;
    localparam logic [7:0] OFF_VECSTAT = 8'h10;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CPU_PRIO_LSB = 5;
    localparam int unsigned PRIO_MSB_POS = 3;
    localparam int unsigned NEST_DIS_POS = 15;
    localparam int unsigned ALT_SEL_POS = 15;
    localparam logic [2:0] SRC_PRIO_RESET = 3'h4;
    localparam logic [2:0] CPU_PRIO_RESET = 3'h0;
    // ------------------------------------------------------------
    // fixed latencies
    // ------------------------------------------------------------
    localparam int unsigned ENTRY_CYCLES = 3;
    localparam int unsigned RETURN_CYCLES = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_SERVICE, ST_RETURN} vipu_state_t;
endpackage

// [logic/vipu_top.sv]
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - merge all sources into one request
// - each source has its own vector
// - primary table at 000004h, 126 entries
// - entries are 24-bit routine addresses
// - lower vector wins among equals
// - fixed order inside one level
// - constant entry and return latency
// - thirty-two sources implemented
// - alternate table follows primary table
// - select bit chooses alternate table
// - reset bypasses the controller
// - reset clears registers except source priorities (reset to 4), fetch at zero
// - cpu priority in status bits 7:5
// - msb bit shifts levels to 8-15; here the bit stays 0, so levels stay 0-7
// - flags set by hardware, cleared by software
// - per-source enable gates forwarding
// - three-bit source priority, zero disables
// - priority msb is read-only
module vipu_top #(
    parameter int unsigned NSRC = vipu_pkg::IMPL_SOURCES
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // request lines from peripherals and pins
    input wire logic [NSRC-1:0] SRC_REQ,
    input wire logic [NSRC-1:0] SRC_IS_PIN,
    // core side
    output logic CORE_IRQ,
    output logic [6:0] CORE_VECNUM,
    output logic [23:0] CORE_VEC_ADDR,
    output logic [3:0] CORE_LEVEL,
    output logic CORE_ENTER,
    output logic CORE_RESUME,
    output logic [23:0] CORE_RESET_PC,
    input wire logic CORE_RETURN
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int unsigned NW = NSRC / 16;
    localparam int unsigned NP = NSRC / 4;
    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] ena_q;
    logic [2:0] prio_q [NSRC];
    logic [2:0] cpu_prio_q;
    logic prio_msb_q;
    logic nest_dis_q;
    logic alt_sel_q;
    logic [NSRC-1:0] pin_s1_q;
    logic [NSRC-1:0] pin_s2_q;
    logic [NSRC-1:0] pin_s3_q;
    logic [NSRC-1:0] raw_req;
    logic [NSRC-1:0] fl_clr;
    logic [3:0] stack_q [8];
    logic [2:0] sp_q;
    vipu_pkg::vipu_state_t state_q;
    logic [1:0] cnt_q;
    logic [6:0] win_vec;
    logic [2:0] win_prio;
    logic win_valid;
    logic [3:0] cpu_level;
    logic [6:0] held_vec_q;
    logic [2:0] held_prio_q;

    assign cpu_level = {prio_msb_q, cpu_prio_q};

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = REG_WR && (REG_ADDR == off);
    endfunction

    // ------------------------------------------------------------
    // input synchronisers and source edge detect
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= SRC_REQ;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // pins use the synchronised rising edge, peripherals the raw level
    assign raw_req = (SRC_IS_PIN & pin_s2_q & ~pin_s3_q) | (~SRC_IS_PIN & SRC_REQ);

    // ------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_flag
            // writing a zero clears the flag, ones leave it
            assign fl_clr[g] = wr_hit(vipu_pkg::OFF_FLAG0 + 8'(g / 16)) && !REG_WDATA[g % 16];
            always_ff @(posedge CORE_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    flag_q[g] <= 1'b0;
                end else if (raw_req[g]) begin
                    flag_q[g] <= 1'b1;
                end else if (fl_clr[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end
            always_ff @(posedge CORE_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    ena_q[g] <= 1'b0;
                    prio_q[g] <= vipu_pkg::SRC_PRIO_RESET;
                end else begin
                    if (wr_hit(vipu_pkg::OFF_ENA0 + 8'(g / 16))) begin
                        ena_q[g] <= REG_WDATA[g % 16];
                    end
                    if (wr_hit(vipu_pkg::OFF_PRIO_BASE + 8'(g / 4))) begin
                        prio_q[g] <= REG_WDATA[(g % 4) * 4 +: 3];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    always_comb begin
        win_vec = '0;
        win_prio = '0;
        win_valid = 1'b0;
        // scan from the top so the lowest index with the best level wins
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (flag_q[i] && ena_q[i] && prio_q[i] != 3'h0 && prio_q[i] >= win_prio) begin
                win_vec = 7'(i);
                win_prio = prio_q[i];
                win_valid = 1'b1;
            end
        end
        if ({1'b0, win_prio} <= cpu_level) begin
            win_valid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers and cpu priority
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            nest_dis_q <= 1'b0;
            alt_sel_q <= 1'b0;
            prio_msb_q <= 1'b0;
        end else begin
            if (wr_hit(vipu_pkg::OFF_ICTL1)) begin
                nest_dis_q <= REG_WDATA[vipu_pkg::NEST_DIS_POS];
            end
            if (wr_hit(vipu_pkg::OFF_ICTL2)) begin
                alt_sel_q <= REG_WDATA[vipu_pkg::ALT_SEL_POS];
            end
            // core control writes never reach the msb bit
            prio_msb_q <= prio_msb_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cpu_prio_q <= vipu_pkg::CPU_PRIO_RESET;
            sp_q <= '0;
        end else if (state_q == vipu_pkg::ST_IDLE && win_valid) begin
            stack_q[sp_q] <= cpu_level;
            sp_q <= sp_q + 3'h1;
            cpu_prio_q <= win_prio;
        end else if (state_q == vipu_pkg::ST_RETURN && cnt_q == 2'h0) begin
            cpu_prio_q <= stack_q[sp_q - 3'h1][2:0];
            sp_q <= sp_q - 3'h1;
        end else if (wr_hit(vipu_pkg::OFF_STATUS) && !nest_dis_q) begin
            cpu_prio_q <= REG_WDATA[vipu_pkg::CPU_PRIO_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // entry and return sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= vipu_pkg::ST_IDLE;
            cnt_q <= '0;
            held_vec_q <= '0;
            held_prio_q <= '0;
        end else begin
            unique case (state_q)
                vipu_pkg::ST_IDLE: begin
                    if (win_valid) begin
                        state_q <= vipu_pkg::ST_ENTRY;
                        cnt_q <= 2'(vipu_pkg::ENTRY_CYCLES - 1);
                        held_vec_q <= win_vec;
                        held_prio_q <= win_prio;
                    end
                end
                vipu_pkg::ST_ENTRY: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= vipu_pkg::ST_SERVICE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                vipu_pkg::ST_SERVICE: begin
                    if (CORE_RETURN) begin
                        state_q <= vipu_pkg::ST_RETURN;
                        cnt_q <= 2'(vipu_pkg::RETURN_CYCLES - 1);
                    end
                end
                vipu_pkg::ST_RETURN: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= vipu_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // core outputs
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CORE_IRQ <= 1'b0;
            CORE_VECNUM <= '0;
            CORE_VEC_ADDR <= vipu_pkg::PRI_TABLE_BASE;
            CORE_LEVEL <= '0;
            CORE_ENTER <= 1'b0;
            CORE_RESUME <= 1'b0;
            CORE_RESET_PC <= vipu_pkg::RESET_ADDR;
        end else begin
            CORE_IRQ <= (state_q == vipu_pkg::ST_IDLE) && win_valid;
            CORE_ENTER <= (state_q == vipu_pkg::ST_ENTRY) && (cnt_q == 2'h0);
            CORE_RESUME <= (state_q == vipu_pkg::ST_RETURN) && (cnt_q == 2'h0);
            CORE_LEVEL <= cpu_level;
            CORE_RESET_PC <= vipu_pkg::RESET_ADDR;
            if (state_q == vipu_pkg::ST_ENTRY) begin
                CORE_VECNUM <= held_vec_q;
                // trap slots come first; alternate table sits right after primary
                CORE_VEC_ADDR <= vipu_pkg::PRI_TABLE_BASE
                    + (alt_sel_q ? 24'(vipu_pkg::TABLE_ENTRIES) * vipu_pkg::ENTRY_STRIDE : 24'h0)
                    + (24'(vipu_pkg::TRAP_COUNT) + 24'(held_vec_q)) * vipu_pkg::ENTRY_STRIDE;
            end
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= '0;
            if (REG_ADDR == vipu_pkg::OFF_STATUS) begin
                REG_RDATA <= 16'({cpu_prio_q, 5'h00});
            end else if (REG_ADDR == vipu_pkg::OFF_CORE_CTRL) begin
                REG_RDATA <= 16'({prio_msb_q, 3'h0});
            end else if (REG_ADDR == vipu_pkg::OFF_ICTL1) begin
                REG_RDATA <= {nest_dis_q, 15'h0000};
            end else if (REG_ADDR == vipu_pkg::OFF_ICTL2) begin
                REG_RDATA <= {alt_sel_q, 15'h0000};
            end else if (REG_ADDR == vipu_pkg::OFF_VECSTAT) begin
                REG_RDATA <= {1'b0, held_prio_q, 5'h00, held_vec_q};
            end else begin
                for (int w = 0; w < NW; w++) begin
                    if (REG_ADDR == vipu_pkg::OFF_FLAG0 + 8'(w)) begin
                        REG_RDATA <= flag_q[w * 16 +: 16];
                    end
                    if (REG_ADDR == vipu_pkg::OFF_ENA0 + 8'(w)) begin
                        REG_RDATA <= ena_q[w * 16 +: 16];
                    end
                end
                for (int p = 0; p < NP; p++) begin
                    if (REG_ADDR == vipu_pkg::OFF_PRIO_BASE + 8'(p)) begin
                        REG_RDATA <= {1'b0, prio_q[p * 4 + 3], 1'b0, prio_q[p * 4 + 2],
                                      1'b0, prio_q[p * 4 + 1], 1'b0, prio_q[p * 4]};
                    end
                end
            end
        end else begin
            REG_RDATA <= '0;
        end
    end
endmodule
